// ===== logic/dac_ctrl_pkg.sv
// Constants shared by the serial load control of a quad 16-bit converter.
// Assumes one 125 MHz core clock that samples every pin of the link.
package dac_ctrl_pkg;
    localparam int CHANNELS = 4;
    localparam int CODE_W = 16;
    localparam int FRAME_BITS = 24;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FRAME_LAST = 5'h18;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

    // Frame layout: command nibble, channel mask nibble, data word
    localparam int CMD_HI = 23;
    localparam int CMD_LO = 20;
    localparam int MASK_HI = 19;
    localparam int MASK_LO = 16;
    localparam int DATA_HI = 15;
    localparam int DATA_LO = 0;
    localparam int DAISY_BIT = 0;

    localparam logic [3:0] CMD_WRITE_INPUT = 4'h1;
    localparam logic [3:0] CMD_UPDATE_DAC = 4'h2;
    localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
    localparam logic [3:0] CMD_READBACK = 4'h9;
    localparam logic [3:0] CMD_DAISY = 4'hF;

    localparam logic [CODE_W-1:0] ZERO_CODE = 16'h0000;
    localparam logic [CODE_W-1:0] MID_CODE = 16'h8000;
    localparam logic [7:0] READ_PAD = 8'h00;

    // Pin indices into the synchroniser bank
    localparam int PINS = 7;
    localparam int PIN_SCLK = 0;
    localparam int PIN_FRAME = 1;
    localparam int PIN_DIN = 2;
    localparam int PIN_LOAD = 3;
    localparam int PIN_RESET = 4;
    localparam int PIN_RSEL = 5;
    localparam int PIN_SPAN = 6;
    localparam logic [PINS-1:0] PIN_IDLE = 7'h1B;

    // Settling time after core reset before the pin levels are trusted
    localparam int SETTLE_NS = 40;
    localparam int CLK_PERIOD_NS = 8;
    localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam logic [3:0] SETTLE_LAST = 4'(SETTLE_CYCLES);

    typedef enum logic [2:0] {
        ST_INIT = 3'h1,
        ST_IDLE = 3'h2,
        ST_FRAME = 3'h4
    } frame_state_type;
endpackage : dac_ctrl_pkg

// ===== logic/dac_serial_load.sv
// Serial load control of a quad 16-bit voltage-output converter.
// Assumes all link pins are asynchronous to ref_clk and sampled by it.
// Overview of operation
// - Each falling link clock in a frame shifts serial_in into the 24-bit register; past 24 only in daisy mode.
// - Frame select falling opens a frame; next 24 falling edges count.
// - serial_out moves on rising link clock, stable at next fall.
// - serial_out carries daisy-chained frame bits or readback contents.
// - Load strobe falling copies pending input to converter registers.
// - Strobe held low lets writes update converter registers at once.
// - Reset pin acts asynchronously to link clock, on its falling edge.
// - While reset pin is low, load strobe pulses are ignored.
// - Reset loads input and converter registers with selected code.
// - Power-up gives zero scale if select low, midscale if high.
// - Span select sets span of all channels: low single, high double.
// - After power-on, outputs hold reset code until a valid write frame.
`timescale 1ns/100ps
module dac_serial_load (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic frame_select_n,
    input wire logic serial_in,
    input wire logic load_outputs_n,
    input wire logic level_reset_n,
    input wire logic reset_level_select,
    input wire logic span_select,
    output logic serial_out,
    output logic serial_out_oe_n,
    output logic span_double,
    output logic [dac_ctrl_pkg::CODE_W-1:0] dac_code_a,
    output logic [dac_ctrl_pkg::CODE_W-1:0] dac_code_b,
    output logic [dac_ctrl_pkg::CODE_W-1:0] dac_code_c,
    output logic [dac_ctrl_pkg::CODE_W-1:0] dac_code_d
);
    import dac_ctrl_pkg::*;

    logic [PINS-1:0] pin_raw;
    logic [PINS-1:0] lvl;
    logic [PINS-1:0] rise;
    logic [PINS-1:0] fall;

    frame_state_type state_q;
    logic [3:0] settle_q;
    logic [CNT_W-1:0] cnt_q;
    logic [FRAME_BITS-1:0] shift_q;
    logic [FRAME_BITS-1:0] tx_q;
    logic daisy_q;
    logic out_q;
    logic oe_n_q;
    logic span_q;
    logic [CODE_W-1:0] in_q [CHANNELS];
    logic [CODE_W-1:0] dac_q [CHANNELS];
    logic [CHANNELS-1:0] pending_q;

    logic commit;
    logic init_done;
    logic reset_event;
    logic load_event;
    logic [3:0] cmd;
    logic [CHANNELS-1:0] mask;
    logic [CODE_W-1:0] data;
    logic [CODE_W-1:0] reset_code;

    function automatic logic [1:0] first_channel(
        input logic [CHANNELS-1:0] m
    );
        logic [1:0] idx;
        idx = 2'h0;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (m[i]) begin
                idx = 2'(i);
            end
        end
        return idx;
    endfunction : first_channel

    assign pin_raw[PIN_SCLK] = sclk;
    assign pin_raw[PIN_FRAME] = frame_select_n;
    assign pin_raw[PIN_DIN] = serial_in;
    assign pin_raw[PIN_LOAD] = load_outputs_n;
    assign pin_raw[PIN_RESET] = level_reset_n;
    assign pin_raw[PIN_RSEL] = reset_level_select;
    assign pin_raw[PIN_SPAN] = span_select;

    generate
        for (genvar p = 0; p < PINS; p++) begin : g_pin
            pin_sync #(.IDLE(PIN_IDLE[p])) u_sync (
                .clk(ref_clk),
                .rst(rst),
                .pin(pin_raw[p]),
                .level(lvl[p]),
                .rose(rise[p]),
                .fell(fall[p])
            );
        end
    endgenerate

    assign cmd = shift_q[CMD_HI:CMD_LO];
    assign mask = shift_q[MASK_HI:MASK_LO];
    assign data = shift_q[DATA_HI:DATA_LO];
    assign reset_code = lvl[PIN_RSEL] ? MID_CODE : ZERO_CODE;
    assign init_done = (state_q == ST_INIT) && (settle_q == SETTLE_LAST);
    assign commit = (state_q == ST_FRAME) && rise[PIN_FRAME]
                    && (cnt_q == FRAME_LAST);
    assign reset_event = (state_q != ST_INIT) && fall[PIN_RESET];
    assign load_event = fall[PIN_LOAD] && lvl[PIN_RESET]
                        && (state_q != ST_INIT);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_INIT;
            settle_q <= 4'h0;
        end else begin
            case (state_q)
                ST_INIT: begin
                    settle_q <= settle_q + 4'h1;
                    if (init_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (fall[PIN_FRAME]) begin
                        state_q <= ST_FRAME;
                    end
                end
                ST_FRAME: begin
                    if (rise[PIN_FRAME]) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_INIT;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= CNT_ZERO;
            shift_q <= '0;
        end else if (state_q == ST_IDLE && fall[PIN_FRAME]) begin
            cnt_q <= CNT_ZERO;
        end else if (state_q == ST_FRAME && fall[PIN_SCLK]) begin
            // Daisy mode keeps shifting so extra bits pass down the chain
            if (cnt_q != FRAME_LAST || daisy_q) begin
                shift_q <= {shift_q[FRAME_BITS-2:0], lvl[PIN_DIN]};
            end
            if (cnt_q != FRAME_LAST) begin
                cnt_q <= cnt_q + CNT_ONE;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            daisy_q <= 1'b0;
            tx_q <= '0;
        end else if (commit && cmd == CMD_DAISY) begin
            daisy_q <= shift_q[DAISY_BIT];
        end else if (commit && cmd == CMD_READBACK) begin
            tx_q <= {READ_PAD, in_q[first_channel(mask)]};
        end else if (state_q == ST_FRAME && rise[PIN_SCLK]) begin
            tx_q <= {tx_q[FRAME_BITS-2:0], 1'b0};
        end
    end

    // output moves on rising link clock only
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            out_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= ~(state_q == ST_FRAME);
            if (state_q == ST_FRAME && rise[PIN_SCLK]) begin
                out_q <= daisy_q ? shift_q[FRAME_BITS-1]
                                 : tx_q[FRAME_BITS-1];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            span_q <= 1'b0;
        end else begin
            span_q <= lvl[PIN_SPAN];
        end
    end

    // Input and converter registers, pending flags
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int c = 0; c < CHANNELS; c++) begin
                in_q[c] <= ZERO_CODE;
                dac_q[c] <= ZERO_CODE;
            end
            pending_q <= '0;
        end else if (init_done || reset_event) begin
            for (int c = 0; c < CHANNELS; c++) begin
                in_q[c] <= reset_code;
                dac_q[c] <= reset_code;
            end
            pending_q <= '0;
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                if (load_event && pending_q[c]) begin
                    dac_q[c] <= in_q[c];
                    pending_q[c] <= 1'b0;
                end
                if (commit && mask[c]) begin
                    if (cmd == CMD_WRITE_INPUT || cmd == CMD_WRITE_UPDATE)
                    begin
                        in_q[c] <= data;
                    end
                    // strobe held low updates at once
                    if (cmd == CMD_WRITE_UPDATE ||
                        (cmd == CMD_WRITE_INPUT && !lvl[PIN_LOAD])) begin
                        dac_q[c] <= data;
                        pending_q[c] <= 1'b0;
                    end else if (cmd == CMD_UPDATE_DAC) begin
                        dac_q[c] <= in_q[c];
                        pending_q[c] <= 1'b0;
                    end else if (cmd == CMD_WRITE_INPUT) begin
                        // New data wins over a strobe clearing the same cycle
                        pending_q[c] <= 1'b1;
                    end
                end
            end
        end
    end

    // converter codes only change through the paths above
    assign dac_code_a = dac_q[0];
    assign dac_code_b = dac_q[1];
    assign dac_code_c = dac_q[2];
    assign dac_code_d = dac_q[3];
    assign serial_out = out_q;
    assign serial_out_oe_n = oe_n_q;
    assign span_double = span_q;

    property p_capture;
        @(posedge ref_clk) disable iff (rst)
        state_q == ST_FRAME && fall[PIN_SCLK] && cnt_q != FRAME_LAST
        |=> shift_q[0] == $past(lvl[PIN_DIN]);
    endproperty
    a_capture: assert property (p_capture)
        else $error("serial bit not captured");

    property p_frame_start;
        @(posedge ref_clk) disable iff (rst)
        state_q == ST_IDLE && fall[PIN_FRAME]
        |=> state_q == ST_FRAME && cnt_q == CNT_ZERO;
    endproperty
    a_frame_start: assert property (p_frame_start)
        else $error("frame did not start");

    property p_out_on_rise;
        @(posedge ref_clk) disable iff (rst)
        $changed(out_q) |-> $past(rise[PIN_SCLK]);
    endproperty
    a_out_on_rise: assert property (p_out_on_rise)
        else $error("serial_out moved off a rising edge");

    property p_daisy_out;
        @(posedge ref_clk) disable iff (rst)
        daisy_q && state_q == ST_FRAME && rise[PIN_SCLK]
        |=> serial_out == $past(shift_q[FRAME_BITS-1]);
    endproperty
    a_daisy_out: assert property (p_daisy_out)
        else $error("daisy bit wrong");

    property p_load;
        @(posedge ref_clk) disable iff (rst)
        load_event && pending_q[0] && !commit && !reset_event
        |=> dac_code_a == $past(in_q[0]) ##1 dac_code_a == $past(in_q[0], 2);
    endproperty
    a_load: assert property (p_load)
        else $error("strobe did not copy channel a");

    property p_sync_mode;
        @(posedge ref_clk) disable iff (rst)
        commit && cmd == CMD_WRITE_INPUT && mask[1] && !lvl[PIN_LOAD]
        && !reset_event |=> dac_code_b == $past(data);
    endproperty
    a_sync_mode: assert property (p_sync_mode)
        else $error("write with strobe low did not update");

    property p_reset_code;
        @(posedge ref_clk) disable iff (rst)
        reset_event |=> dac_code_c == $past(reset_code)
                        && in_q[2] == $past(reset_code) && pending_q == '0;
    endproperty
    a_reset_code: assert property (p_reset_code)
        else $error("reset code not loaded");

    property p_ignore_load;
        @(posedge ref_clk) disable iff (rst)
        fall[PIN_LOAD] && !lvl[PIN_RESET] && !commit && !reset_event
        |=> $stable(dac_code_d) && $stable(dac_code_a);
    endproperty
    a_ignore_load: assert property (p_ignore_load)
        else $error("strobe honoured while reset low");

    property p_power_up;
        @(posedge ref_clk) disable iff (rst)
        init_done |=> state_q == ST_IDLE
            && dac_code_a == ($past(lvl[PIN_RSEL]) ? MID_CODE : ZERO_CODE);
    endproperty
    a_power_up: assert property (p_power_up)
        else $error("power-up code wrong");

    property p_span;
        @(posedge ref_clk) disable iff (rst)
        ##1 span_double == $past(lvl[PIN_SPAN]);
    endproperty
    a_span: assert property (p_span)
        else $error("span does not follow pin");

    property p_short_frame;
        @(posedge ref_clk) disable iff (rst)
        state_q == ST_FRAME && rise[PIN_FRAME] && cnt_q != FRAME_LAST
        && !load_event && !reset_event
        |=> $stable(in_q[0]) && $stable(dac_code_a) && $stable(daisy_q);
    endproperty
    a_short_frame: assert property (p_short_frame)
        else $error("short frame changed state");

    c_commit: cover property (@(posedge ref_clk) disable iff (rst) commit);
    c_load: cover property (@(posedge ref_clk) disable iff (rst)
        load_event && pending_q != '0);
    c_reset: cover property (@(posedge ref_clk) disable iff (rst)
        reset_event);
    c_daisy: cover property (@(posedge ref_clk) disable iff (rst)
        daisy_q && commit);
endmodule : dac_serial_load

// ===== logic/pin_sync.sv
// Three-stage synchroniser with agreement filter for one link pin.
// Assumes the pin is asynchronous to clk; first stage feeds only the second.
`timescale 1ns/100ps
module pin_sync #(
    parameter logic IDLE = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output logic level,
    output logic rose,
    output logic fell
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    logic level_d;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= IDLE;
            s2_q <= IDLE;
            s3_q <= IDLE;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts only once the second and third stages agree
    always_comb begin
        level_d = level_q;
        if (s2_q == s3_q) begin
            level_d = s3_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level_q <= IDLE;
        end else begin
            level_q <= level_d;
        end
    end

    assign level = level_q;
    assign rose = level_d & ~level_q;
    assign fell = ~level_d & level_q;
endmodule : pin_sync

// ===== tb/dac_host_model.sv
// Host serial controller model that drives frames into the load control.
// Assumes the bench calls send_frame; the link clock idles high between frames.
`timescale 1ns/100ps
module dac_host_model (
    output logic sclk,
    output logic frame_select_n,
    output logic serial_in,
    input wire logic serial_out,
    output logic [63:0] rx_bits
);
    localparam real HALF_NS = 62.5;

    initial begin
        sclk = 1'b1;
        frame_select_n = 1'b1;
        serial_in = 1'b0;
        rx_bits = 64'h0;
    end

    // Sends n bits MSB first and samples serial_out at every falling edge
    task automatic send_frame(input logic [47:0] bits, input int n);
        frame_select_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = bits[i];
            #(HALF_NS);
            // sample while the device holds its bit
            rx_bits = {rx_bits[62:0], serial_out};
            sclk = 1'b0;
            #(HALF_NS);
            if (i > 0) begin
                sclk = 1'b1;
            end
        end
        // Select rises before the clock so no extra shift-out edge lands
        frame_select_n = 1'b1;
        #(HALF_NS);
        sclk = 1'b1;
        // Released data line shows the inverse of its last bit
        serial_in = ~serial_in;
        // gap well beyond the update spacing
        // no power-down frames are sent, so no settling wait
        #(1000);
    endtask : send_frame
endmodule : dac_host_model

// ===== tb/dac_serial_load_tb.sv
// Self-checking bench for the serial load control with a reference model.
// Assumes the host model owns the link pins; the bench owns all the others.
`timescale 1ns/100ps
module dac_serial_load_tb;
    import dac_ctrl_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic load_outputs_n = 1'b1;
    // reset pin high from power-up on
    logic level_reset_n = 1'b1;
    logic reset_level_select = 1'b1;
    logic span_select = 1'b0;
    logic sclk, frame_select_n, serial_in, serial_out, serial_out_oe_n;
    logic span_double;
    logic [CODE_W-1:0] dac_code_a, dac_code_b, dac_code_c, dac_code_d;
    logic [63:0] rx_bits;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int unsigned seed = 17260;
    int m_in [4];
    int m_dac [4];
    bit m_pend [4];
    int m_rb = 0;
    bit oe_low_seen = 1'b0;

    always #4 ref_clk = ~ref_clk;

    always @(negedge ref_clk) begin
        if (!serial_out_oe_n) begin
            oe_low_seen = 1'b1;
        end
    end

    dac_serial_load dut (.ref_clk(ref_clk), .rst(rst), .sclk(sclk),
        .frame_select_n(frame_select_n), .serial_in(serial_in),
        .load_outputs_n(load_outputs_n), .level_reset_n(level_reset_n),
        .reset_level_select(reset_level_select), .span_select(span_select),
        .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
        .span_double(span_double), .dac_code_a(dac_code_a),
        .dac_code_b(dac_code_b), .dac_code_c(dac_code_c),
        .dac_code_d(dac_code_d));

    dac_host_model host (.sclk(sclk), .frame_select_n(frame_select_n),
        .serial_in(serial_in), .serial_out(serial_out), .rx_bits(rx_bits));

    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xorshift

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check_codes();
        logic [CODE_W-1:0] seen [4];
        seen = '{dac_code_a, dac_code_b, dac_code_c, dac_code_d};
        for (int i = 0; i < CHANNELS; i++) begin
            chk(32'(seen[i]), m_dac[i], "channel code");
        end
        chk(32'(serial_out_oe_n), 32'h1, "output enable idle");
    endtask : check_codes

    task automatic model_frame(input logic [23:0] w);
        logic [3:0] cmd;
        logic [3:0] mask;
        int data;
        cmd = w[CMD_HI:CMD_LO];
        mask = w[MASK_HI:MASK_LO];
        data = int'(w[DATA_HI:DATA_LO]);
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (mask[i]) begin
                case (cmd)
                    CMD_WRITE_INPUT: begin
                        m_in[i] = data;
                        m_pend[i] = load_outputs_n;
                        if (!load_outputs_n) m_dac[i] = data;
                    end
                    CMD_UPDATE_DAC: begin
                        m_dac[i] = m_in[i];
                        m_pend[i] = 1'b0;
                    end
                    CMD_WRITE_UPDATE: begin
                        m_in[i] = data;
                        m_dac[i] = data;
                        m_pend[i] = 1'b0;
                    end
                    CMD_READBACK: m_rb = m_in[i];
                    default: ;
                endcase
            end
        end
    endtask : model_frame

    task automatic frame(input logic [23:0] w);
        host.send_frame({24'h0, w}, FRAME_BITS);
        model_frame(w);
        check_codes();
    endtask : frame

    task automatic pulse_load();
        @(negedge ref_clk) load_outputs_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        load_outputs_n = 1'b1;
        model_strobe();
        repeat (8) @(negedge ref_clk);
        check_codes();
    endtask : pulse_load

    task automatic model_strobe();
        // strobe counts only with the reset pin high
        for (int i = 0; i < CHANNELS; i++) begin
            if (m_pend[i] && level_reset_n) begin
                m_dac[i] = m_in[i];
                m_pend[i] = 1'b0;
            end
        end
    endtask : model_strobe

    function automatic logic [23:0] rnd_word(input logic [3:0] cmd);
        logic [31:0] r;
        r = xorshift();
        return {cmd, r[19:0]};
    endfunction : rnd_word

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            $display("BAD %0t run did not finish in time", $time);
            tally_and_finish();
        end
    end

    initial begin
        logic [23:0] a;
        logic [23:0] b;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk) rst = 1'b0;
        repeat (20) @(negedge ref_clk);
        for (int i = 0; i < CHANNELS; i++) begin
            m_in[i] = MID_CODE;
            m_dac[i] = MID_CODE;
        end
        check_codes();
        span_select = 1'b1;
        repeat (8) @(negedge ref_clk);
        chk(32'(span_double), 32'h1, "span double");
        span_select = 1'b0;
        repeat (8) @(negedge ref_clk);
        chk(32'(span_double), 32'h0, "span single");
        for (int k = 0; k < 6; k++) begin
            frame(rnd_word(CMD_WRITE_INPUT));
        end
        pulse_load();
        // Short frame must leave channel and daisy registers alone
        host.send_frame({28'h0, CMD_WRITE_UPDATE, 16'hFFFF}, 20);
        check_codes();
        frame(rnd_word(CMD_WRITE_UPDATE));
        frame({CMD_WRITE_INPUT, 4'hF, 16'hFFFF});
        frame({CMD_UPDATE_DAC, 4'h5, 16'h0000});
        // Lowering the strobe to hold it low is itself a pulse
        @(negedge ref_clk) load_outputs_n = 1'b0;
        repeat (8) @(negedge ref_clk);
        model_strobe();
        check_codes();
        // Channel b always in the mask so the held-low path is exercised
        frame(rnd_word(CMD_WRITE_INPUT) | 24'h020000);
        @(negedge ref_clk) load_outputs_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        frame({CMD_READBACK, 4'h6, 16'h0000});
        frame({CMD_WRITE_INPUT, 4'h0, 16'h0000});
        chk(32'(rx_bits[22:0]), 32'(m_rb) >> 1, "readback");
        frame({CMD_DAISY, 4'h0, 16'h0001});
        a = rnd_word(CMD_WRITE_INPUT);
        b = rnd_word(CMD_WRITE_UPDATE);
        host.send_frame({a, b}, 48);
        model_frame(b);
        check_codes();
        chk(32'(rx_bits[23:0]), 32'(a), "daisy pass-on");
        frame({CMD_DAISY, 4'h0, 16'h0000});
        @(negedge ref_clk) reset_level_select = 1'b0;
        frame({CMD_WRITE_INPUT, 4'hF, 16'h1357});
        @(negedge ref_clk) level_reset_n = 1'b0;
        repeat (10) @(negedge ref_clk);
        // reset pin loads the selected code
        for (int i = 0; i < CHANNELS; i++) begin
            m_in[i] = ZERO_CODE;
            m_dac[i] = ZERO_CODE;
            m_pend[i] = 1'b0;
        end
        check_codes();
        frame(rnd_word(CMD_WRITE_INPUT));
        pulse_load();
        @(negedge ref_clk) level_reset_n = 1'b1;
        repeat (10) @(negedge ref_clk);
        check_codes();
        pulse_load();
        chk(32'(oe_low_seen), 32'h1, "output enabled in frame");
        tally_and_finish();
    end
endmodule : dac_serial_load_tb
